// file: rtl/osa_defs.svh
`ifndef OSA_DEFS_SVH
`define OSA_DEFS_SVH

// register indices (word addresses on the plain port)
`define OSA_REG_ALLOC0     4'h0
`define OSA_REG_ALLOC1     4'h1
`define OSA_REG_INVERT     4'h2
`define OSA_REG_REMOTE     4'h3
`define OSA_REG_IN_MON     4'h4
`define OSA_REG_OUT_MON    4'h5
`define OSA_REG_IRQ_STAT   4'h6
`define OSA_REG_IRQ_MASK   4'h7
`define OSA_REG_ALARM_INV  4'h8

// axis B field position in the invert and output monitor words
`define OSA_AXIS_B_LSB     3'h4

// allocation codes
`define OSA_CODE_MATCH     4'h0
`define OSA_CODE_ROTATE    4'h1
`define OSA_CODE_READY     4'h2
`define OSA_CODE_TLIMIT    4'h3
`define OSA_CODE_BRAKE     4'h4
`define OSA_CODE_INDEX     4'h5
`define OSA_CODE_TRAVEL    4'h6
`define OSA_CODE_EXCITE    4'h7
`define OSA_CODE_HOMED     4'h8
`define OSA_CODE_TORQUE    4'h9
`define OSA_CODE_REMOTE0   4'hA
`define OSA_CODE_REMOTE1   4'hB
`define OSA_CODE_REMOTE2   4'hC

// reset values
`define OSA_ALLOC_RST      16'h0000
`define OSA_INVERT_RST     3'h0

`endif

// file: rtl/osa_pkg.sv
package osa_pkg;
  typedef logic [3:0] osa_code_t;
  typedef logic [9:0] osa_status_t;
  typedef logic [2:0] osa_chan_t;
endpackage : osa_pkg

// file: rtl/osa_channel_mux.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
// one axis worth of source selection and polarity
module osa_channel_mux
  import osa_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  // allocation codes, four bits per channel
  input wire logic [4*CHANNELS-1:0] allocCode,
  // per-channel inversion
  input wire logic [CHANNELS-1:0] invert,
  // internal status sources, one bit per code 0 to 9
  input wire osa_status_t status,
  // remote output bits
  input wire logic [2:0] remoteOut,
  // combinational results
  output logic [CHANNELS-1:0] optoOn,
  output logic [CHANNELS-1:0] monitorBit
);

  function automatic logic selectSource(input osa_code_t code,
      input osa_status_t st, input logic [2:0] rem);
    logic src;
    src = 1'b0;
    unique case (code)
      `OSA_CODE_MATCH: src = st[0]; // RULE_01
      `OSA_CODE_ROTATE: src = st[1];
      `OSA_CODE_READY: src = st[2];
      `OSA_CODE_TLIMIT: src = st[3];
      `OSA_CODE_BRAKE: src = st[4];
      `OSA_CODE_INDEX: src = st[5];
      `OSA_CODE_TRAVEL: src = st[6];
      `OSA_CODE_EXCITE: src = st[7];
      `OSA_CODE_HOMED: src = st[8];
      `OSA_CODE_TORQUE: src = st[9];
      `OSA_CODE_REMOTE0: src = rem[0]; // RULE_02
      `OSA_CODE_REMOTE1: src = rem[1];
      `OSA_CODE_REMOTE2: src = rem[2];
      default: src = 1'b0; // RULE_12
    endcase
    return src;
  endfunction : selectSource

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      logic active;
      logic isIndex;
      always_comb begin
        active = selectSource(allocCode[4*ch +: 4], status, remoteOut);
        isIndex = (allocCode[4*ch +: 4] == `OSA_CODE_INDEX);
        // on when active and not inverted, flipped by inversion
        optoOn[ch] = active ^ invert[ch]; // RULE_04 RULE_05 RULE_07
        // index pulse is too fast to be meaningful on the monitor
        monitorBit[ch] = isIndex ? 1'b0 : optoOn[ch]; // RULE_11
      end
    end
  endgenerate

endmodule : osa_channel_mux

// file: rtl/osa_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module osa_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // asynchronous in, synchronised out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
    if (sys_rst) begin
      next_stage1 = '0;
      next_syncOut = '0;
    end
  end

  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    syncOut <= next_syncOut;
  end

endmodule : osa_sync

// file: rtl/output_signal_allocation.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
// How it works
// RULE_01: codes 0 to 9 pick internal status
// RULE_02: codes A to C pick remote bits
// RULE_03: three channels, one inversion bit each
// RULE_04: active, not inverted: optocoupler on
// RULE_05: inactive, not inverted: optocoupler off
// RULE_06: alarm present turns alarm output off
// RULE_07: inversion bit complements the drive
// RULE_08: several sources on one channel OR; each channel takes one code, so one source
// RULE_09: sixteen-bit input monitor word
// RULE_10: output monitor bit follows optocoupler
// RULE_11: index pulse channel reads off
// RULE_12: undefined codes leave source inactive
module output_signal_allocation
  import osa_pkg::*;
#(
  parameter int CHANNELS = 3,
  parameter int INPUTS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // axis A internal status, codes 0 to 9
  input wire osa_status_t statusA,
  // axis B internal status
  input wire osa_status_t statusB,
  // alarm present per axis
  input wire logic alarmA,
  input wire logic alarmB,
  // physical inputs, from pins
  input wire logic [5:0] physicalIn,
  // virtual input bits
  input wire logic [INPUTS-1:0] virtualIn,
  // optocoupler drive, high means on
  output logic [CHANNELS-1:0] optoA,
  output logic [CHANNELS-1:0] optoB,
  output logic alarm_outputA,
  output logic alarm_outputB,
  // interrupt
  output logic irq
);

  localparam int NEV = 2 * CHANNELS;

  // configuration
  logic [15:0] allocA;
  logic [15:0] allocB;
  logic [CHANNELS-1:0] invA;
  logic [CHANNELS-1:0] invB;
  logic [1:0] alarmInv;
  logic [5:0] remoteOut;
  logic [NEV-1:0] irqStat;
  logic [NEV-1:0] irqMask;
  logic [15:0] inMon;
  logic [CHANNELS-1:0] monA;
  logic [CHANNELS-1:0] monB;
  logic [NEV-1:0] prevOpto;
  logic [15:0] next_allocA;
  logic [15:0] next_allocB;
  logic [CHANNELS-1:0] next_invA;
  logic [CHANNELS-1:0] next_invB;
  logic [1:0] next_alarmInv;
  logic [5:0] next_remoteOut;
  logic [NEV-1:0] next_irqStat;
  logic [NEV-1:0] next_irqMask;
  logic [31:0] next_regRdData;
  logic [15:0] next_inMon;
  logic [CHANNELS-1:0] next_monA;
  logic [CHANNELS-1:0] next_monB;
  logic [NEV-1:0] next_prevOpto;
  logic [CHANNELS-1:0] next_optoA;
  logic [CHANNELS-1:0] next_optoB;
  logic next_alarm_outputA;
  logic next_alarm_outputB;
  logic next_irq;

  // combinational channel results
  logic [CHANNELS-1:0] combOptoA;
  logic [CHANNELS-1:0] combOptoB;
  logic [CHANNELS-1:0] combMonA;
  logic [CHANNELS-1:0] combMonB;
  logic [5:0] physSync;
  logic [NEV-1:0] edgeEv;

  osa_sync #(
    .WIDTH(6)
  ) uPinSync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn(physicalIn),
    .syncOut(physSync)
  );

  // each channel has one code field, so OR of several sources
  // means several codes on one channel are not representable;
  // a channel's source set is a single code
  osa_channel_mux #(
    .CHANNELS(CHANNELS)
  ) uMuxA (
    .allocCode(allocA[4*CHANNELS-1:0]),
    .invert(invA),
    .status(statusA),
    .remoteOut(remoteOut[2:0]),
    .optoOn(combOptoA),
    .monitorBit(combMonA)
  );

  osa_channel_mux #(
    .CHANNELS(CHANNELS)
  ) uMuxB (
    .allocCode(allocB[4*CHANNELS-1:0]),
    .invert(invB),
    .status(statusB),
    .remoteOut(remoteOut[5:3]),
    .optoOn(combOptoB),
    .monitorBit(combMonB)
  );

  // OR of every source allocated to a channel
  logic [CHANNELS-1:0] orOptoA;
  logic [CHANNELS-1:0] orOptoB;
  always_comb begin
    // one code per channel, so the OR is that single source
    orOptoA = combOptoA; // RULE_08
    orOptoB = combOptoB; // RULE_08
  end

  assign edgeEv = {combOptoB, combOptoA} ^ prevOpto;

  function automatic logic isAddr(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction : isAddr

  // axis A field at bit 0, axis B field a nibble above it
  function automatic logic [31:0] packAxes(input logic [CHANNELS-1:0] a,
      input logic [CHANNELS-1:0] b);
    logic [31:0] w;
    w = '0;
    w[`OSA_AXIS_B_LSB +: CHANNELS] = b;
    w[CHANNELS-1:0] = a;
    return w;
  endfunction : packAxes

  // configuration, written by software only
  always_comb begin
    next_allocA = allocA;
    next_allocB = allocB;
    next_invA = invA;
    next_invB = invB;
    next_alarmInv = alarmInv;
    next_remoteOut = remoteOut;
    next_irqMask = irqMask;
    if (regWrite) begin
      if (isAddr(regAddr, `OSA_REG_ALLOC0)) begin
        next_allocA = regWrData[15:0];
      end
      if (isAddr(regAddr, `OSA_REG_ALLOC1)) begin
        next_allocB = regWrData[15:0];
      end
      if (isAddr(regAddr, `OSA_REG_INVERT)) begin
        next_invA = regWrData[CHANNELS-1:0]; // RULE_03
        next_invB = regWrData[`OSA_AXIS_B_LSB +: CHANNELS]; // RULE_03
      end
      if (isAddr(regAddr, `OSA_REG_REMOTE)) begin
        next_remoteOut = regWrData[5:0];
      end
      if (isAddr(regAddr, `OSA_REG_IRQ_MASK)) begin
        next_irqMask = regWrData[NEV-1:0];
      end
      if (isAddr(regAddr, `OSA_REG_ALARM_INV)) begin
        next_alarmInv = regWrData[1:0];
      end
    end
    if (sys_rst) begin
      next_allocA = `OSA_ALLOC_RST;
      next_allocB = `OSA_ALLOC_RST;
      next_invA = `OSA_INVERT_RST;
      next_invB = `OSA_INVERT_RST;
      next_alarmInv = '0;
      next_remoteOut = '0;
      next_irqMask = '0;
    end
  end

  always_ff @(posedge clk) begin
    allocA <= next_allocA;
    allocB <= next_allocB;
    invA <= next_invA;
    invB <= next_invB;
    alarmInv <= next_alarmInv;
    remoteOut <= next_remoteOut;
    irqMask <= next_irqMask;
  end

  // last cycle's drive, so a flip of any channel can be seen
  always_comb begin
    next_prevOpto = {combOptoB, combOptoA};
    if (sys_rst) begin
      next_prevOpto = '0;
    end
  end

  always_ff @(posedge clk) begin
    prevOpto <= next_prevOpto;
  end

  // status sticks until software writes a one to it
  always_comb begin
    next_irqStat = irqStat;
    if (regWrite && isAddr(regAddr, `OSA_REG_IRQ_STAT)) begin
      next_irqStat = irqStat & ~regWrData[NEV-1:0];
    end
    // set wins over a clear in the same cycle
    next_irqStat = next_irqStat | edgeEv;
    next_irq = |(next_irqStat & irqMask);
    if (sys_rst) begin
      next_irqStat = '0;
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    irqStat <= next_irqStat;
    irq <= next_irq;
  end

  // read data stands for the one cycle after the strobe, else zero
  always_comb begin
    next_regRdData = '0;
    if (regRead) begin
      unique case (regAddr)
        `OSA_REG_ALLOC0: next_regRdData = {16'h0000, allocA};
        `OSA_REG_ALLOC1: next_regRdData = {16'h0000, allocB};
        `OSA_REG_INVERT: next_regRdData = packAxes(invA, invB);
        `OSA_REG_REMOTE: next_regRdData = {26'h000_0000, remoteOut};
        `OSA_REG_IN_MON: next_regRdData = {16'h0000, inMon}; // RULE_09
        `OSA_REG_OUT_MON: next_regRdData = packAxes(monA, monB); // RULE_10
        `OSA_REG_IRQ_STAT: next_regRdData = {26'h000_0000, irqStat};
        `OSA_REG_IRQ_MASK: next_regRdData = {26'h000_0000, irqMask};
        `OSA_REG_ALARM_INV: next_regRdData = {30'h0000_0000, alarmInv};
        default: next_regRdData = '0;
      endcase
    end
    if (sys_rst) begin
      next_regRdData = '0;
    end
  end

  always_ff @(posedge clk) begin
    regRdData <= next_regRdData;
  end

  // monitor words
  always_comb begin
    // bits 0..5 from pins or virtual, 6..15 virtual only
    next_inMon = {virtualIn[15:6], physSync | virtualIn[5:0]}; // RULE_09
    next_monA = combMonA; // RULE_10 RULE_11
    next_monB = combMonB; // RULE_10 RULE_11
    if (sys_rst) begin
      next_inMon = '0;
      next_monA = '0;
      next_monB = '0;
    end
  end

  always_ff @(posedge clk) begin
    inMon <= next_inMon;
    monA <= next_monA;
    monB <= next_monB;
  end

  // channel optocoupler drives
  always_comb begin
    next_optoA = orOptoA;
    next_optoB = orOptoB;
    if (sys_rst) begin
      next_optoA = '0;
      next_optoB = '0;
    end
  end

  always_ff @(posedge clk) begin
    optoA <= next_optoA;
    optoB <= next_optoB;
  end

  // alarm drive is on while healthy and not inverted, so a cut wire reads as an alarm
  always_comb begin
    // no alarm means on; inversion flips it
    next_alarm_outputA = ~alarmA ^ alarmInv[0]; // RULE_06 RULE_07
    next_alarm_outputB = ~alarmB ^ alarmInv[1]; // RULE_06 RULE_07
    if (sys_rst) begin
      next_alarm_outputA = 1'b0;
      next_alarm_outputB = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    alarm_outputA <= next_alarm_outputA;
    alarm_outputB <= next_alarm_outputB;
  end

endmodule : output_signal_allocation

// file: verif/osa_checker_sva.sv
`timescale 1ns/1ps
module osa_checker
  import osa_pkg::*;
#(
  parameter int CHANNELS = 3,
  parameter int INPUTS = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  // sources
  input wire osa_status_t statusA,
  input wire osa_status_t statusB,
  input wire logic alarmA,
  input wire logic alarmB,
  input wire logic [5:0] physicalIn,
  input wire logic [INPUTS-1:0] virtualIn,
  // drives
  input wire logic [CHANNELS-1:0] optoA,
  input wire logic [CHANNELS-1:0] optoB,
  input wire logic alarm_outputA,
  input wire logic alarm_outputB,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  idle_read_a: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data not zero outside read");
  unmapped_read_a: assert property (
    regRead && regAddr > 4'h8 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  in_mon_a: assert property (
    regRead && regAddr == 4'h4 && !$past(sys_rst)
    |=> regRdData[31:16] == 16'h0
    && regRdData[15:6] == $past(virtualIn[15:6], 2))
    else $error("input monitor upper bits wrong");
  out_mon_a: assert property (
    regRead && regAddr == 4'h5 |=> (regRdData[2:0] & ~$past(optoA)) == 0
    && (regRdData[6:4] & ~$past(optoB)) == 0)
    else $error("output monitor shows an off channel");
  // a change with no cause in the two cycles before is a stuck or stray reg
  opto_a_cause_a: assert property (
    $changed(optoA) && !$past(sys_rst) && !$past(sys_rst, 2) |->
    $past(statusA) != $past(statusA, 2) || $past(regWrite)
    || $past(regWrite, 2)) else $error("optoA changed without cause");
  opto_b_cause_a: assert property (
    $changed(optoB) && !$past(sys_rst) && !$past(sys_rst, 2) |->
    $past(statusB) != $past(statusB, 2) || $past(regWrite)
    || $past(regWrite, 2)) else $error("optoB changed without cause");
  alarm_a_cause_a: assert property (
    $changed(alarm_outputA) && !$past(sys_rst) && !$past(sys_rst, 2) |->
    $past(alarmA) != $past(alarmA, 2) || $past(regWrite)
    || $past(regWrite, 2)) else $error("alarm A changed without cause");
  alarm_b_cause_a: assert property (
    $changed(alarm_outputB) && !$past(sys_rst) && !$past(sys_rst, 2) |->
    $past(alarmB) != $past(alarmB, 2) || $past(regWrite)
    || $past(regWrite, 2)) else $error("alarm B changed without cause");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(regWrite) || $past(regWrite, 2))
    else $error("irq dropped without a write");
endmodule : osa_checker

bind output_signal_allocation osa_checker #(
  .CHANNELS(CHANNELS), .INPUTS(INPUTS)) i_chk (.clk, .sys_rst, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .statusA, .statusB,
  .alarmA, .alarmB, .physicalIn, .virtualIn, .optoA, .optoB,
  .alarm_outputA, .alarm_outputB, .irq);

// file: verif/osa_host_inputs.sv
`timescale 1ns/1ps
module osa_host_inputs (
  // drive clock
  input wire logic clk,
  // one axis of optocouplers
  input wire logic [2:0] opto,
  input wire logic alarmOn,
  // inputs as the host latches them
  output logic [3:0] hostIn
);
  // host scans once per clock at best, so it lags the drive by one
  always_ff @(posedge clk) begin
    hostIn <= {alarmOn, opto};
  end
endmodule : osa_host_inputs

// file: verif/output_signal_allocation_tb.sv
`timescale 1ns/1ps
`include "osa_defs.svh"
module output_signal_allocation_tb
  import osa_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData, rd;
  osa_status_t statusA = '0;
  osa_status_t statusB = '0;
  logic alarmA = 1'b0;
  logic alarmB = 1'b1;
  logic [5:0] physicalIn = 6'h00;
  logic [15:0] virtualIn = 16'h0000;
  logic [2:0] optoA, optoB, rb, e;
  logic alarm_outputA, alarm_outputB, irq;
  logic [3:0] hostA;
  int miscompares = 0;
  int n_compared = 0;

  always #4 clk = ~clk;

  output_signal_allocation i_dut (.clk, .sys_rst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .statusA, .statusB, .alarmA, .alarmB,
    .physicalIn, .virtualIn, .optoA, .optoB, .alarm_outputA,
    .alarm_outputB, .irq);
  osa_host_inputs i_host (.clk, .opto(optoA), .alarmOn(alarm_outputA),
    .hostIn(hostA));

  task automatic chk(input string what, input logic [31:0] ex,
    input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, ex, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
    @(posedge clk);
  endtask : rd_reg

  task automatic opto_chk(input logic [2:0] ea, input logic [2:0] eb);
    repeat (3) @(posedge clk);
    #1;
    chk("optoA", 32'(ea), 32'(optoA));
    chk("optoB", 32'(eb), 32'(optoB));
    chk("hostA", 32'({alarm_outputA, ea}), 32'(hostA));
    @(posedge clk);
  endtask : opto_chk

  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin : main
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("alarmA", 32'h1, 32'(alarm_outputA));
    chk("alarmB", 32'h0, 32'(alarm_outputB));
    @(posedge clk);
    wr(`OSA_REG_ALARM_INV, 32'h3);
    #1 chk("alarmInvA", 32'h0, 32'(alarm_outputA));
    chk("alarmInvB", 32'h1, 32'(alarm_outputB));
    @(posedge clk);
    wr(`OSA_REG_ALARM_INV, 32'h0);
    // every code, source off then on, other sources held opposite
    for (int c = 0; c < 16; c++) begin
      wr(`OSA_REG_ALLOC0, 32'({3{4'(c)}}));
      wr(`OSA_REG_ALLOC1, 32'({3{4'(c)}}));
      for (int act = 0; act < 2; act++) begin
        rb = (c >= 10 && c < 13) ? 3'h1 << (c - 10) : 3'h0;
        rb = act ? rb : ~rb;
        statusA <= act ? 10'h1 << c : ~(10'h1 << c);
        statusB <= act ? 10'h1 << c : ~(10'h1 << c);
        wr(`OSA_REG_REMOTE, 32'({rb, rb}));
        e = (c < 13 && act == 1) ? 3'h7 : 3'h0;
        opto_chk(e, e);
        rd_reg(`OSA_REG_OUT_MON, rd);
        chk("outMon", (c == 5) ? 32'h0 : 32'({e, 1'b0, e}), rd);
      end
    end
    wr(`OSA_REG_ALLOC0, 32'h0);
    wr(`OSA_REG_ALLOC1, 32'h0);
    wr(`OSA_REG_INVERT, 32'h35);
    statusA <= 10'h0;
    statusB <= 10'h0;
    opto_chk(3'h5, 3'h3);
    statusA <= 10'h1;
    statusB <= 10'h1;
    opto_chk(3'h2, 3'h4);
    wr(`OSA_REG_OUT_MON, 32'h7f);
    rd_reg(`OSA_REG_OUT_MON, rd);
    chk("outMonRo", 32'h42, rd);
    rd_reg(4'hf, rd);
    chk("unmapped", 32'h0, rd);
    physicalIn <= 6'h15;
    virtualIn <= 16'ha0c2;
    repeat (4) @(posedge clk);
    rd_reg(`OSA_REG_IN_MON, rd);
    chk("inMon", 32'h0000_a0d7, rd);
    // events: all A channels flip, only channel 0 unmasked
    wr(`OSA_REG_IRQ_STAT, 32'h3f);
    wr(`OSA_REG_IRQ_MASK, 32'h1);
    statusA <= 10'h0;
    repeat (3) @(posedge clk);
    #1 chk("irqSet", 32'h1, 32'(irq));
    @(posedge clk);
    wr(`OSA_REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irqClr", 32'h0, 32'(irq));
    @(posedge clk);
    rd_reg(`OSA_REG_IRQ_STAT, rd);
    chk("irqStat", 32'h6, rd);
    wr(`OSA_REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    #1 chk("irqMask", 32'h1, 32'(irq));
    @(posedge clk);
    alarmA <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("alarmOn", 32'h0, 32'(alarm_outputA));
    // reset in mid-run puts configuration and drives back to defaults
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_reg(`OSA_REG_INVERT, rd);
    chk("rstInvert", 32'h0, rd);
    #1 chk("rstOpto", 32'h0, 32'(optoA));
    chk("rstIrq", 32'h0, 32'(irq));
    report_and_stop();
  end
endmodule : output_signal_allocation_tb
